// File: fpc_top.sv
// Flash program controller: mode, command and status registers plus
// the sequencer that turns commands into array operations.
// Assumes a flash array that acknowledges each op with arr_rdy_i.
//
// How it works
// - Program done raises interrupt when enabled
// - Lock done raises interrupt when enabled
// - Lock error raises interrupt when enabled
// - Command error raises interrupt when enabled
// - Skip-erase bit chooses page pre-erase
// - Wait-state field sets access lengths
// - Code zero does nothing, no error
// - Code one programs the given page
// - Codes two/four lock/unlock page's region
// - Code three programs then locks region
// - Code eight erases all unless locked
// - Other codes start nothing, flag error
// - Page field bits 17:8, unused ignored
// - Key 0x5A required to start anything
// - Bad code or key sets error bit
// - Program done bit set on completion
// - Lock done bit set on completion
// - Lock error bit on locked target
// - Upper status bits show region locks
// - Status read clears flags and interrupt
// - Locked target leaves array untouched
// - No array access during lock ops
module fpc_top
	import fpc_pkg::*;
#(
	parameter logic [REGIONS-1:0] LOCK_INIT = '0 // Locks at reset
)
(
	input  wire logic                   sys_clk_i,   // System clock
	input  wire logic                   resetn_i,    // Async reset, low
	input  wire logic [fpc_pkg::ADDR_W-1:0] addr_i,  // Register offset
	input  wire logic [31:0]            wdata_i,     // Write data
	input  wire logic                   wr_i,        // Write strobe
	input  wire logic                   rd_i,        // Read strobe
	output logic      [31:0]            rdata_o,     // Read data
	output logic                        irq_o,       // Controller interrupt
	input  wire logic                   arr_rdy_i,   // Array op finished
	output logic                        arr_req_o,   // Array op request
	output fpc_pkg::fpc_op_t            arr_op_o,    // Array op code
	output logic [fpc_pkg::PAGE_W-1:0]  arr_page_o,  // Array page
	output logic                        arr_busy_o,  // Array access blocked
	output logic      [2:0]             rd_cyc_o,    // Read access cycles
	output logic      [2:0]             wr_cyc_o     // Write access cycles
);
	import fpc_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// Reset release
	logic [1:0] rst_sync_ff;
	logic       rst_n;

	always_ff @(posedge sys_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			rst_sync_ff <= 2'b00;
		end
		else
		begin
			rst_sync_ff <= {rst_sync_ff[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_ff[1];

	////////////////////////////////////////////////////////////////////////
	// Sequencer state
	typedef enum logic [2:0] {
		S_IDLE,
		S_ERASE,
		S_PROG,
		S_LOCK,
		S_ERASE_ALL
	} fpc_state_t;

	typedef struct packed {
		fpc_state_t        state;
		logic [31:0]       mode;
		logic              eop;
		logic              lock_done_flag;
		logic              locked_region_error;
		logic              bad_command_error;
		logic [REGIONS-1:0] locks;
		logic [PAGE_W-1:0] page;
		logic              then_lock;
		logic              lock_set;
		logic              start;
		fpc_op_t           op;
		logic [31:0]       rdata;
		logic              irq;
		logic              busy;
	} fpc_top_t;

	fpc_top_t st_ff;
	fpc_top_t nxt_st;
	fpc_op_if op_bus ();

	// Lock region holding a page
	function automatic logic [3:0] region_of(input logic [PAGE_W-1:0] pg);
		region_of = pg[PAGE_W-1:REGION_SHIFT];
	endfunction

	logic              cmd_wr;
	logic [7:0]        cmd_key;
	logic [3:0]        cmd_code;
	logic [PAGE_W-1:0] cmd_page;
	logic              stat_rd;
	logic              op_done;

	assign cmd_wr   = wr_i && (addr_i == OFS_CMD);
	assign cmd_key  = wdata_i[CMD_KEY_LSB +: 8];
	assign cmd_code = wdata_i[CMD_CODE_LSB +: 4];
	assign cmd_page = wdata_i[CMD_PAGE_LSB +: PAGE_W];
	assign stat_rd  = rd_i && (addr_i == OFS_STATUS);
	assign op_done  = op_bus.done;

	////////////////////////////////////////////////////////////////////////
	// Next state
	always_comb
	begin
		nxt_st       = st_ff;
		nxt_st.start = 1'b0;
		nxt_st.rdata = 32'h0000_0000;

		// Read clears first so that same-cycle events survive
		if (stat_rd)
		begin
			nxt_st.eop   = 1'b0;
			nxt_st.lock_done_flag   = 1'b0;
			nxt_st.locked_region_error = 1'b0;
			nxt_st.bad_command_error = 1'b0;
		end

		if (wr_i && addr_i == OFS_MODE)
		begin
			nxt_st.mode = wdata_i & MODE_WMASK;
		end

		if (cmd_wr)
		begin
			if (cmd_key != CMD_KEY)
			begin
				nxt_st.bad_command_error = 1'b1;
			end
			else if (st_ff.state == S_IDLE)
			begin
				case (cmd_code)
					FPC_CMD_NONE:
					begin
						nxt_st.state = S_IDLE;
					end
					FPC_CMD_WP, FPC_CMD_WPL:
					begin
						if (st_ff.locks[region_of(cmd_page)])
						begin
							nxt_st.locked_region_error = 1'b1;
						end
						else
						begin
							nxt_st.eop       = 1'b0;
							nxt_st.page      = cmd_page;
							nxt_st.then_lock = (cmd_code == FPC_CMD_WPL);
							nxt_st.start     = 1'b1;
							if (st_ff.mode[MODE_SKIP_PAGE_ERASE_BIT])
							begin
								nxt_st.state = S_PROG;
								nxt_st.op    = FPC_OP_PROG_PAGE;
							end
							else
							begin
								nxt_st.state = S_ERASE;
								nxt_st.op    = FPC_OP_ERASE_PAGE;
							end
						end
					end
					FPC_CMD_SLB, FPC_CMD_CLB:
					begin
						nxt_st.lock_done_flag      = 1'b0;
						nxt_st.page     = cmd_page;
						nxt_st.lock_set = (cmd_code == FPC_CMD_SLB);
						nxt_st.start    = 1'b1;
						nxt_st.state    = S_LOCK;
						nxt_st.op       = (cmd_code == FPC_CMD_SLB) ?
							FPC_OP_LOCK : FPC_OP_UNLOCK;
					end
					FPC_CMD_EA:
					begin
						if (|st_ff.locks)
						begin
							nxt_st.locked_region_error = 1'b1;
						end
						else
						begin
							nxt_st.eop   = 1'b0;
							nxt_st.start = 1'b1;
							nxt_st.state = S_ERASE_ALL;
							nxt_st.op    = FPC_OP_ERASE_ALL;
						end
					end
					default:
					begin
						nxt_st.bad_command_error = 1'b1;
					end
				endcase
			end
		end

		case (st_ff.state)
			S_ERASE:
			begin
				if (op_done)
				begin
					nxt_st.start = 1'b1;
					nxt_st.op    = FPC_OP_PROG_PAGE;
					nxt_st.state = S_PROG;
				end
			end
			S_PROG:
			begin
				if (op_done)
				begin
					nxt_st.eop = 1'b1;
					if (st_ff.then_lock)
					begin
						nxt_st.start    = 1'b1;
						nxt_st.lock_set = 1'b1;
						nxt_st.lock_done_flag      = 1'b0;
						nxt_st.op       = FPC_OP_LOCK;
						nxt_st.state    = S_LOCK;
					end
					else
					begin
						nxt_st.state = S_IDLE;
					end
				end
			end
			S_LOCK:
			begin
				if (op_done)
				begin
					nxt_st.lock_done_flag = 1'b1;
					nxt_st.locks[region_of(st_ff.page)] = st_ff.lock_set;
					nxt_st.state = S_IDLE;
				end
			end
			S_ERASE_ALL:
			begin
				if (op_done)
				begin
					nxt_st.eop   = 1'b1;
					nxt_st.state = S_IDLE;
				end
			end
			default:
			begin
				// Idle: the command decode above picks the next op
			end
		endcase

		nxt_st.busy = (nxt_st.state == S_LOCK);

		// Register reads; command and reserved slots read zero
		if (rd_i)
		begin
			if (addr_i == OFS_MODE)
			begin
				nxt_st.rdata = st_ff.mode;
			end
			else if (addr_i == OFS_STATUS)
			begin
				nxt_st.rdata = 32'h0000_0000;
				nxt_st.rdata[STAT_LOCKS_LSB +: REGIONS] = st_ff.locks;
				nxt_st.rdata[STAT_EOP_BIT]   = st_ff.eop;
				nxt_st.rdata[STAT_EOL_BIT]   = st_ff.lock_done_flag;
				nxt_st.rdata[STAT_LOCKED_REGION_ERROR_BIT] = st_ff.locked_region_error;
				nxt_st.rdata[STAT_BAD_COMMAND_ERROR_BIT] = st_ff.bad_command_error;
			end
			else
			begin
				nxt_st.rdata = 32'h0000_0000;
			end
		end

		nxt_st.irq = (nxt_st.eop   && nxt_st.mode[MODE_EOP_EN_BIT])
		          || (nxt_st.lock_done_flag   && nxt_st.mode[MODE_EOL_EN_BIT])
		          || (nxt_st.locked_region_error && nxt_st.mode[MODE_LOCKED_REGION_ERROR_EN_BIT])
		          || (nxt_st.bad_command_error && nxt_st.mode[MODE_BAD_COMMAND_ERROR_EN_BIT]);
	end

	////////////////////////////////////////////////////////////////////////
	// State register
	always_ff @(posedge sys_clk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			st_ff <= '{state: S_IDLE, mode: MODE_RESET, eop: 1'b0, lock_done_flag: 1'b0,
				locked_region_error: 1'b0, bad_command_error: 1'b0, locks: LOCK_INIT, page: '0,
				then_lock: 1'b0, lock_set: 1'b0, start: 1'b0,
				op: FPC_OP_IDLE, rdata: 32'h0000_0000, irq: 1'b0, busy: 1'b0};
		end
		else
		begin
			st_ff <= nxt_st;
		end
	end

	assign op_bus.start = st_ff.start;
	assign op_bus.op    = st_ff.op;
	assign op_bus.page  = st_ff.page;

	////////////////////////////////////////////////////////////////////////
	// Submodules
	fpc_op_driver u_drv (
		.clk_i      (sys_clk_i),
		.rst_n_i    (rst_n),
		.op_if      (op_bus),
		.arr_rdy_i  (arr_rdy_i),
		.arr_req_o  (arr_req_o),
		.arr_op_o   (arr_op_o),
		.arr_page_o (arr_page_o)
	);

	fpc_wait_state u_ws (
		.clk_i    (sys_clk_i),
		.rst_n_i  (rst_n),
		.fws_i    (st_ff.mode[MODE_FWS_LSB +: 2]),
		.rd_cyc_o (rd_cyc_o),
		.wr_cyc_o (wr_cyc_o)
	);

	assign rdata_o    = st_ff.rdata;
	assign irq_o      = st_ff.irq;
	assign arr_busy_o = st_ff.busy;
endmodule

// File: fpc_pkg.sv
// Shared constants and types of the flash program controller.
// Assumes a single 200 MHz system clock and a plain register port.
package fpc_pkg;

	localparam int          ADDR_W            = 8;
	localparam logic [7:0]  OFS_MODE          = 8'h60;
	localparam logic [7:0]  OFS_CMD           = 8'h64;
	localparam logic [7:0]  OFS_STATUS        = 8'h68;
	localparam logic [7:0]  OFS_RSVD          = 8'h6C;

	localparam int          MODE_EOP_EN_BIT   = 0;
	localparam int          MODE_EOL_EN_BIT   = 1;
	localparam int          MODE_LOCKED_REGION_ERROR_EN_BIT = 2;
	localparam int          MODE_BAD_COMMAND_ERROR_EN_BIT = 3;
	localparam int          MODE_SKIP_PAGE_ERASE_BIT     = 7;
	localparam int          MODE_FWS_LSB      = 8;
	localparam int          MODE_TIMING_CYCLE_COUNT_LSB     = 16;
	localparam logic [31:0] MODE_RESET        = 32'h0000_0000;
	localparam logic [31:0] MODE_WMASK        = 32'h00FF_038F;

	localparam int          CMD_CODE_LSB      = 0;
	localparam int          CMD_PAGE_LSB      = 8;
	localparam int          CMD_KEY_LSB       = 24;
	localparam logic [7:0]  CMD_KEY           = 8'h5A;

	localparam int          STAT_EOP_BIT      = 0;
	localparam int          STAT_EOL_BIT      = 1;
	localparam int          STAT_LOCKED_REGION_ERROR_BIT    = 2;
	localparam int          STAT_BAD_COMMAND_ERROR_BIT    = 3;
	localparam int          STAT_LOCKS_LSB    = 16;

	localparam int          PAGE_W            = 10;
	localparam int          REGIONS           = 16;
	localparam int          REGION_SHIFT      = 6;

	typedef enum logic [3:0] {
		FPC_CMD_NONE  = 4'h0,
		FPC_CMD_WP    = 4'h1,
		FPC_CMD_SLB   = 4'h2,
		FPC_CMD_WPL   = 4'h3,
		FPC_CMD_CLB   = 4'h4,
		FPC_CMD_EA    = 4'h8
	} fpc_cmd_t;

	// Array operation codes handed to the flash macro
	typedef enum logic [2:0] {
		FPC_OP_IDLE,
		FPC_OP_ERASE_PAGE,
		FPC_OP_PROG_PAGE,
		FPC_OP_LOCK,
		FPC_OP_UNLOCK,
		FPC_OP_ERASE_ALL
	} fpc_op_t;

	// Access length per wait-state value
	localparam logic [2:0]  RD_CYC_0          = 3'h1;
	localparam logic [2:0]  RD_CYC_1          = 3'h2;
	localparam logic [2:0]  RD_CYC_2          = 3'h3;
	localparam logic [2:0]  RD_CYC_3          = 3'h4;
	localparam logic [2:0]  WR_CYC_0          = 3'h2;
	localparam logic [2:0]  WR_CYC_1          = 3'h3;
	localparam logic [2:0]  WR_CYC_2          = 3'h4;
	localparam logic [2:0]  WR_CYC_3          = 3'h4;

endpackage

// File: fpc_op_if.sv
// Request and completion wires between the sequencer and the op starter.
// Assumes both ends run on the same clock.
interface fpc_op_if;
	import fpc_pkg::*;
	logic                start;
	fpc_op_t             op;
	logic [PAGE_W-1:0]   page;
	logic                done;

	modport seq   (output start, output op, output page, input done);
	modport drv   (input start, input op, input page, output done);
endinterface

// File: fpc_wait_state.sv
// Decodes the wait-state field into read and write access lengths.
// Assumes the mode register value is stable between writes.
module fpc_wait_state
	import fpc_pkg::*;
(
	input  wire logic       clk_i,   // System clock
	input  wire logic       rst_n_i, // Synchronised reset
	input  wire logic [1:0] fws_i,   // Wait-state field
	output logic      [2:0] rd_cyc_o, // Read access cycles
	output logic      [2:0] wr_cyc_o  // Write access cycles
);
	typedef struct packed {
		logic [2:0] rd;
		logic [2:0] wr;
	} fpc_ws_t;

	fpc_ws_t st_ff;
	fpc_ws_t nxt_st;

	always_comb
	begin
		nxt_st = st_ff;
		case (fws_i)
			2'd0:
			begin
				nxt_st.rd = RD_CYC_0;
				nxt_st.wr = WR_CYC_0;
			end
			2'd1:
			begin
				nxt_st.rd = RD_CYC_1;
				nxt_st.wr = WR_CYC_1;
			end
			2'd2:
			begin
				nxt_st.rd = RD_CYC_2;
				nxt_st.wr = WR_CYC_2;
			end
			default:
			begin
				nxt_st.rd = RD_CYC_3;
				nxt_st.wr = WR_CYC_3;
			end
		endcase
	end

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			st_ff <= '{rd: RD_CYC_0, wr: WR_CYC_0};
		end
		else
		begin
			st_ff <= nxt_st;
		end
	end

	assign rd_cyc_o = st_ff.rd;
	assign wr_cyc_o = st_ff.wr;
endmodule

// File: fpc_op_driver.sv
// Drives one array operation to the flash and reports its completion.
// Assumes the array answers each request with a one-cycle ready pulse.
module fpc_op_driver
	import fpc_pkg::*;
(
	input  wire logic                clk_i,     // System clock
	input  wire logic                rst_n_i,   // Synchronised reset
	fpc_op_if.drv                    op_if,     // Sequencer side
	input  wire logic                arr_rdy_i, // Array finished op
	output logic                     arr_req_o, // Array request level
	output fpc_op_t                  arr_op_o,  // Array op code
	output logic [PAGE_W-1:0]        arr_page_o // Array page
);
	typedef struct packed {
		logic              req;
		fpc_op_t           op;
		logic [PAGE_W-1:0] page;
		logic              done;
	} fpc_drv_t;

	fpc_drv_t st_ff;
	fpc_drv_t nxt_st;

	always_comb
	begin
		nxt_st      = st_ff;
		nxt_st.done = 1'b0;
		if (op_if.start && !st_ff.req)
		begin
			nxt_st.req  = 1'b1;
			nxt_st.op   = op_if.op;
			nxt_st.page = op_if.page;
		end
		else if (st_ff.req && arr_rdy_i)
		begin
			nxt_st.req  = 1'b0;
			nxt_st.op   = FPC_OP_IDLE;
			nxt_st.done = 1'b1;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			st_ff <= '{req: 1'b0, op: FPC_OP_IDLE, page: '0, done: 1'b0};
		end
		else
		begin
			st_ff <= nxt_st;
		end
	end

	assign op_if.done = st_ff.done;
	assign arr_req_o  = st_ff.req;
	assign arr_op_o   = st_ff.op;
	assign arr_page_o = st_ff.page;
endmodule

// File: fpc_properties.sv
// Port-level checker for the flash program controller.
// Assumes it is bound to fpc_top and sees only that module's ports.
module fpc_properties
	import fpc_pkg::*;
(
	input  wire logic                       sys_clk_i,  // Clock
	input  wire logic                       resetn_i,   // Reset, low
	input  wire logic [fpc_pkg::ADDR_W-1:0] addr_i,     // Offset
	input  wire logic [31:0]                wdata_i,    // Write data
	input  wire logic                       wr_i,       // Write strobe
	input  wire logic                       rd_i,       // Read strobe
	input  wire logic [31:0]                rdata_o,    // Read data
	input  wire logic                       irq_o,      // Interrupt
	input  wire logic                       arr_rdy_i,  // Array done
	input  wire logic                       arr_req_o,  // Array request
	input  wire fpc_pkg::fpc_op_t           arr_op_o,   // Array op
	input  wire logic [fpc_pkg::PAGE_W-1:0] arr_page_o, // Array page
	input  wire logic                       arr_busy_o, // Array blocked
	input  wire logic [2:0]                 rd_cyc_o,   // Read cycles
	input  wire logic [2:0]                 wr_cyc_o    // Write cycles
);
	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (!resetn_i);

	// Page of the last finished op, for the erase-then-program pairing
	logic [PAGE_W-1:0] pg_ff;
	always_ff @(posedge sys_clk_i)
	begin
		if (arr_req_o && arr_rdy_i)
			pg_ff <= arr_page_o;
	end

	////////////////////////////////////////////////////////////////////
	a_ws_pairing: assert property (rd_cyc_o inside {3'h1, 3'h2, 3'h3, 3'h4}
		&& wr_cyc_o == ((rd_cyc_o == 3'h4) ? 3'h4 : rd_cyc_o + 3'h1))
		else $error("wait-state pair wrong");
	a_wo_read_zero: assert property (rd_i && (addr_i == OFS_CMD || addr_i == OFS_RSVD)
		|=> rdata_o == 32'h0000_0000) else $error("write-only slot read not zero");
	a_rdata_idle_zero: assert property (!rd_i
		|=> rdata_o == 32'h0000_0000) else $error("read data outside read cycle");
	a_mode_masked: assert property (rd_i && addr_i == OFS_MODE
		|=> (rdata_o & ~MODE_WMASK) == 32'h0000_0000) else $error("mode unused bits set");
	a_status_spare: assert property (rd_i && addr_i == OFS_STATUS
		|=> rdata_o[15:4] == 12'h000) else $error("status spare bits set");
	a_read_clears_irq: assert property (rd_i && addr_i == OFS_STATUS && !wr_i
		&& !$past(wr_i) && !$past(wr_i, 2) && !arr_rdy_i && !$past(arr_rdy_i)
		|=> !irq_o) else $error("irq kept after status read");
	a_busy_lock_op: assert property (arr_req_o
		&& arr_op_o inside {FPC_OP_LOCK, FPC_OP_UNLOCK} |-> arr_busy_o)
		else $error("array not blocked in lock op");
	a_req_holds: assert property (arr_req_o && !arr_rdy_i
		|=> arr_req_o && $stable(arr_op_o) && $stable(arr_page_o))
		else $error("array request changed before ready");
	a_req_drops: assert property (arr_req_o && arr_rdy_i |=> !arr_req_o)
		else $error("array request kept after ready");
	a_erase_then_prog: assert property ($fell(arr_req_o)
		&& $past(arr_op_o) == FPC_OP_ERASE_PAGE |-> ##[1:8]
		(arr_req_o && arr_op_o == FPC_OP_PROG_PAGE && arr_page_o == pg_ff))
		else $error("page erase not followed by program");
endmodule

bind fpc_top fpc_properties u_props (
	.sys_clk_i  (sys_clk_i),
	.resetn_i   (resetn_i),
	.addr_i     (addr_i),
	.wdata_i    (wdata_i),
	.wr_i       (wr_i),
	.rd_i       (rd_i),
	.rdata_o    (rdata_o),
	.irq_o      (irq_o),
	.arr_rdy_i  (arr_rdy_i),
	.arr_req_o  (arr_req_o),
	.arr_op_o   (arr_op_o),
	.arr_page_o (arr_page_o),
	.arr_busy_o (arr_busy_o),
	.rd_cyc_o   (rd_cyc_o),
	.wr_cyc_o   (wr_cyc_o)
);

// File: fpc_array_model.sv
// Behavioural flash array: answers each request after a set delay.
// Assumes requests hold until the ready pulse has been seen.
module fpc_array_model
	import fpc_pkg::*;
(
	input  wire logic                       clk_i,   // Clock
	input  wire logic                       rst_n_i, // Reset, low
	input  wire logic                       req_i,   // Op request
	input  wire fpc_pkg::fpc_op_t           op_i,    // Op code
	input  wire logic [fpc_pkg::PAGE_W-1:0] page_i,  // Op page
	input  wire logic [3:0]                 delay_i, // Answer delay
	output logic                            rdy_o    // Op finished
);
	timeunit 1ns;
	timeprecision 100ps;
	// Every finished op, for the bench to inspect
	logic [12:0] log_q[$];
	logic [3:0]  cnt;
	always @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			rdy_o <= 1'b0;
			cnt   <= 4'h0;
		end
		else if (rdy_o || !req_i)
		begin
			rdy_o <= 1'b0;
			cnt   <= 4'h0;
		end
		else if (cnt >= delay_i)
		begin
			rdy_o <= 1'b1;
			log_q.push_back({op_i, page_i});
		end
		else
			cnt <= cnt + 4'h1;
	end
endmodule

// File: tb.sv
// Register-level tests of the flash program controller.
// Assumes the array model answers every request it sees.
module tb;
	timeunit 1ns;
	timeprecision 100ps;
	import fpc_pkg::*;
	logic        clk = 1'b0;
	logic        rstn = 1'b0;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	logic [7:0]  addr = 8'h00;
	logic [31:0] wdata = 32'h0000_0000;
	logic [3:0]  dly = 4'h1;
	logic [31:0] rdata;
	logic        irq;
	logic        req;
	logic        busy;
	logic        rdy;
	fpc_op_t     op;
	logic [9:0]  page;
	logic [2:0]  rc;
	logic [2:0]  wc;
	int          fails = 0;
	int          samples_checked = 0;
	int          idx = 0;
	logic [2:0]  rt[4] = '{3'h1, 3'h2, 3'h3, 3'h4};
	logic [2:0]  wt[4] = '{3'h2, 3'h3, 3'h4, 3'h4};
	// Timing counts at 5 ns: 100 ns is 20; 1.5 us needs 300, so the field saturates
	logic [31:0] t_lock = 32'h0014_0000;
	logic [31:0] t_prog = 32'h00FF_0000;

	always #2.5 clk = ~clk;

	fpc_top dut (.sys_clk_i(clk), .resetn_i(rstn), .addr_i(addr), .wdata_i(wdata),
		.wr_i(wr), .rd_i(rd), .rdata_o(rdata), .irq_o(irq), .arr_rdy_i(rdy),
		.arr_req_o(req), .arr_op_o(op), .arr_page_o(page), .arr_busy_o(busy),
		.rd_cyc_o(rc), .wr_cyc_o(wc));
	fpc_array_model arr (.clk_i(clk), .rst_n_i(rstn), .req_i(req), .op_i(op),
		.page_i(page), .delay_i(dly), .rdy_o(rdy));

	////////////////////////////////////////////////////////////////////
	task automatic complete_run();
		$display("Checks %0d, mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		samples_checked++;
		if (got !== exp)
		begin
			fails++;
			$display("MISMATCH %0t %s got %h", $time, m, got);
		end
	endtask
	task automatic wrr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rdr(input logic [7:0] a, input logic [31:0] exp, input string m);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1 chk(rdata, exp, m);
	endtask
	// Issues a command and waits for n array ops to finish
	task automatic cmd(input logic [3:0] c, input logic [9:0] p, input logic [7:0] k, int n);
		int i;
		wrr(OFS_CMD, {k, 6'h00, p, 4'h0, c});
		for (i = 0; i < 400 && arr.log_q.size() < idx + n; i++)
			@(posedge clk);
		if (i == 400)
		begin
			fails++;
			$display("MISMATCH %0t array op missing", $time);
			complete_run();
		end
		repeat (20) @(posedge clk);
		chk(arr.log_q.size(), idx + n, "array op count");
	endtask
	task automatic exp_op(input fpc_op_t o, input logic [9:0] p);
		chk(arr.log_q[idx], {o, p}, "array op");
		idx++;
	endtask

	////////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (8) @(posedge clk);
		rstn <= 1'b1;
		repeat (3) @(posedge clk);
		rdr(OFS_MODE, 32'h0000_0000, "mode reset");
		rdr(OFS_STATUS, 32'h0000_0000, "status reset");
		rdr(OFS_CMD, 32'h0000_0000, "cmd read");
		rdr(OFS_RSVD, 32'h0000_0000, "reserved read");
		for (int f = 0; f < 4; f++)
		begin
			wrr(OFS_MODE, 32'(f) << MODE_FWS_LSB);
			repeat (3) @(posedge clk);
			chk(32'(rc), 32'(rt[f]), "read cycles");
			chk(32'(wc), 32'(wt[f]), "write cycles");
		end
		wrr(OFS_MODE, 32'hFFFF_FFFF);
		rdr(OFS_MODE, MODE_WMASK, "mode mask");
		$display("Test registers done");
		wrr(OFS_MODE, t_prog | 32'h0000_0001);
		dly <= 4'h7;
		cmd(4'h1, 10'h005, 8'h5A, 2);
		exp_op(FPC_OP_ERASE_PAGE, 10'h005);
		exp_op(FPC_OP_PROG_PAGE, 10'h005);
		chk(32'(irq), 32'h1, "eop irq");
		rdr(OFS_STATUS, 32'h0000_0001, "eop set");
		chk(32'(irq), 32'h0, "irq cleared");
		rdr(OFS_STATUS, 32'h0000_0000, "flags cleared");
		wrr(OFS_MODE, t_prog | 32'h0000_0080);
		dly <= 4'h1;
		cmd(4'h1, 10'h3FF, 8'h5A, 1);
		exp_op(FPC_OP_PROG_PAGE, 10'h3FF);
		chk(32'(irq), 32'h0, "eop masked");
		rdr(OFS_STATUS, 32'h0000_0001, "eop no erase");
		$display("Test program done");
		wrr(OFS_MODE, t_lock | 32'h0000_0082);
		cmd(4'h2, 10'h045, 8'h5A, 1);
		exp_op(FPC_OP_LOCK, 10'h045);
		chk(32'(irq), 32'h1, "eol irq");
		rdr(OFS_STATUS, 32'h0002_0002, "region 1 locked");
		wrr(OFS_MODE, t_prog | 32'h0000_0084);
		cmd(4'h1, 10'h041, 8'h5A, 0);
		chk(32'(irq), 32'h1, "locked_region_error irq");
		rdr(OFS_STATUS, 32'h0002_0004, "lock error");
		cmd(4'h8, 10'h000, 8'h5A, 0);
		rdr(OFS_STATUS, 32'h0002_0004, "erase all refused");
		wrr(OFS_MODE, t_lock | 32'h0000_0080);
		cmd(4'h4, 10'h07F, 8'h5A, 1);
		exp_op(FPC_OP_UNLOCK, 10'h07F);
		chk(32'(irq), 32'h0, "eol masked");
		rdr(OFS_STATUS, 32'h0000_0002, "region 1 unlocked");
		wrr(OFS_MODE, t_prog | 32'h0000_0081);
		cmd(4'h8, 10'h155, 8'h5A, 1);
		chk(32'(arr.log_q[idx][12:10]), 32'(FPC_OP_ERASE_ALL), "erase all");
		idx++;
		chk(32'(irq), 32'h1, "erase irq");
		rdr(OFS_STATUS, 32'h0000_0001, "erase done");
		wrr(OFS_MODE, t_lock | 32'h0000_0083);
		cmd(4'h3, 10'h080, 8'h5A, 2);
		exp_op(FPC_OP_PROG_PAGE, 10'h080);
		exp_op(FPC_OP_LOCK, 10'h080);
		rdr(OFS_STATUS, 32'h0004_0003, "program and lock");
		$display("Test lock done");
		wrr(OFS_MODE, t_prog | 32'h0000_0088);
		cmd(4'h1, 10'h010, 8'hA5, 0);
		chk(32'(irq), 32'h1, "bad_command_error irq");
		rdr(OFS_STATUS, 32'h0004_0008, "bad key");
		for (int c = 5; c < 16; c++)
		begin
			if (c != 8)
			begin
				cmd(4'(c), 10'h010, 8'h5A, 0);
				rdr(OFS_STATUS, 32'h0004_0008, "reserved code");
			end
		end
		cmd(4'h0, 10'h010, 8'h5A, 0);
		chk(32'(irq), 32'h0, "no command irq");
		rdr(OFS_STATUS, 32'h0004_0000, "no command");
		wrr(OFS_MODE, t_prog | 32'h0000_0080);
		cmd(4'h1, 10'h010, 8'h00, 0);
		cmd(4'h1, 10'h081, 8'h5A, 0);
		cmd(4'h1, 10'h010, 8'h5A, 1);
		exp_op(FPC_OP_PROG_PAGE, 10'h010);
		chk(32'(irq), 32'h0, "all masked");
		rdr(OFS_STATUS, 32'h0004_000D, "flags gathered");
		$display("Test errors done");
		complete_run();
	end
endmodule
